// file: rtl/fpa_port.sv
// Top of the 4-bit general-purpose port shared with the upper address outputs
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module fpa_port #(
  parameter int PORT_W = fpa_pkg::PORT_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [2:0]           mode,
  input  wire logic                 hw_standby,
  input  wire logic                 sw_standby,
  input  wire fpa_pkg::fpa_bus_req_t bus,
  output logic [7:0]                rdata,
  input  wire logic [PORT_W-1:0]    upper_addr,
  input  wire logic [PORT_W-1:0]    pin_in,
  output logic [PORT_W-1:0]         pin_out,
  output logic [PORT_W-1:0]         pin_oe,
  output logic [PORT_W-1:0]         pullup_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode class

  fpa_pkg::fpa_cls_t      cls_r;
  fpa_pkg::fpa_cls_t      rst_cls;
  logic                   is_addr;
  logic                   is_mixed;
  logic                   init_now;

  fpa_mode_dec u_mode_dec (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .hw_standby (hw_standby),
    .mode       (mode),
    .cls_r      (cls_r)
  );

  // Class seen at the initialising edge, so register init and latch agree
  assign rst_cls  = fpa_pkg::fpa_classify(mode);
  assign init_now = rst || hw_standby;
  assign is_addr  = (cls_r == fpa_pkg::CLS_ADDR);
  assign is_mixed = (cls_r == fpa_pkg::CLS_MIXED);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic                   sel_dir;
  logic                   sel_data;
  logic                   sel_pull;

  always_comb begin
    sel_dir  = 1'b0;
    sel_data = 1'b0;
    sel_pull = 1'b0;
    if (bus.addr == fpa_pkg::ADDR_DIR) begin
      sel_dir = 1'b1;
    end else if (bus.addr == fpa_pkg::ADDR_DATA) begin
      sel_data = 1'b1;
    end else if (bus.addr == fpa_pkg::ADDR_PULL) begin
      sel_pull = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction register

  logic [PORT_W-1:0]      ddr_r;

  // Software standby has no branch here: contents simply hold
  always_ff @(posedge clk_sys) begin
    if (init_now) begin
      if (rst_cls == fpa_pkg::CLS_ADDR) begin
        ddr_r <= fpa_pkg::RST_DIR_ADDR[PORT_W-1:0];
      end else begin
        ddr_r <= fpa_pkg::RST_DIR_IO[PORT_W-1:0];
      end
    end else if (is_addr) begin
      ddr_r <= fpa_pkg::RST_DIR_ADDR[PORT_W-1:0];
    end else if (bus.wr && sel_dir) begin
      ddr_r <= bus.wdata[PORT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data register

  logic [PORT_W-1:0]      dr_r;

  always_ff @(posedge clk_sys) begin
    if (init_now) begin
      dr_r <= fpa_pkg::RST_DATA[PORT_W-1:0];
    end else if (bus.wr && sel_data) begin
      dr_r <= bus.wdata[PORT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up control register

  logic [PORT_W-1:0]      pcr_r;

  always_ff @(posedge clk_sys) begin
    if (init_now) begin
      pcr_r <= fpa_pkg::RST_PULL[PORT_W-1:0];
    end else if (bus.wr && sel_pull) begin
      pcr_r <= bus.wdata[PORT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [PORT_W-1:0]      port_view;
  logic [7:0]             rd_val;

  // Output pins read back the latch, not the pad, so loading does not matter
  assign port_view = (ddr_r & dr_r) | (~ddr_r & pin_in);

  always_comb begin
    rd_val = fpa_pkg::RD_UNMAPPED;
    if (sel_dir) begin
      rd_val = fpa_pkg::RD_DIR_VAL;
    end else if (sel_data) begin
      rd_val = {fpa_pkg::RSVD_ONES, port_view};
    end else if (sel_pull) begin
      rd_val = {fpa_pkg::RSVD_ONES, pcr_r};
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= fpa_pkg::RD_IDLE;
    end else if (bus.rd) begin
      rdata <= rd_val;
    end else begin
      rdata <= fpa_pkg::RD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin function

  fpa_pkg::fpa_pin_ctl_t  ctl;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      fpa_pin_mux u_pin (
        .cls_addr (is_addr),
        .cls_mixed(is_mixed),
        .blocked  (hw_standby),
        .dir      (ddr_r[gi]),
        .data     (dr_r[gi]),
        .pull     (pcr_r[gi]),
        .addr_bit (upper_addr[gi]),
        .pin_out  (ctl.out[gi]),
        .pin_oe   (ctl.oe[gi]),
        .pin_pu   (ctl.pu[gi])
      );
    end
  endgenerate

  // Outputs follow the controls one cycle later; software standby does not
  // touch them, so an output pin keeps its level through standby
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= ctl.out;
      pin_oe  <= ctl.oe;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pullup_on <= '0;
    end else begin
      pullup_on <= ctl.pu;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  AST_ADDR_DRIVE: assert property (
    is_addr && !hw_standby |=> pin_oe == '1 && pin_out == $past(upper_addr)
  ) else $error("Address mode pins not driving the upper address");

  AST_MIXED_DIR: assert property (
    is_mixed && !hw_standby |=> pin_oe == $past(ddr_r)
      && pin_out == ($past(upper_addr) & $past(ddr_r))
  ) else $error("Mixed mode pin does not follow its direction bit");

  AST_MIXED_RESET_IN: assert property (
    $past(rst) && is_mixed |-> ddr_r == '0 ##1 pin_oe == '0
  ) else $error("Mixed mode pin not an input after reset");

  AST_SINGLE_GPIO: assert property (
    !is_addr && !is_mixed && !hw_standby |=> pin_oe == $past(ddr_r)
      && pin_out == ($past(dr_r) & $past(ddr_r))
  ) else $error("Single-chip pin not driven from the data register");

  AST_DIR_LOCKED: assert property (
    is_addr && !init_now |=> ddr_r == '1
  ) else $error("Direction changed in address mode");

  AST_DIR_READ: assert property (
    bus.rd && sel_dir |=> rdata == fpa_pkg::RD_DIR_VAL
  ) else $error("Direction read did not return all ones");

  AST_DIR_WRITE: assert property (
    bus.wr && sel_dir && !is_addr && !init_now |=> ddr_r == $past(bus.wdata[PORT_W-1:0])
  ) else $error("Direction write not taken in modes 5 to 7");

  AST_INIT_VALUES: assert property (
    hw_standby |=> dr_r == fpa_pkg::RST_DATA[PORT_W-1:0]
      && pcr_r == fpa_pkg::RST_PULL[PORT_W-1:0]
      && (is_addr ? ddr_r == '1 : ddr_r == '0)
  ) else $error("Hardware standby did not initialise the registers");

  AST_SW_STANDBY_HOLD: assert property (
    sw_standby && !bus.wr && !hw_standby |=> $stable(ddr_r) && $stable(dr_r)
      && $stable(pcr_r)
  ) else $error("Register changed during software standby");

  AST_PULL_READ: assert property (
    bus.rd && sel_pull |=> rdata == {fpa_pkg::RSVD_ONES, $past(pcr_r)}
  ) else $error("Pull-up control read wrong");

  AST_DATA_READ: assert property (
    bus.rd && sel_data |=> rdata == {fpa_pkg::RSVD_ONES,
      ($past(ddr_r) & $past(dr_r)) | (~$past(ddr_r) & $past(pin_in))}
  ) else $error("Port data read does not mix latch and pin");

  AST_READ_ONE_CYCLE: assert property (
    !bus.rd |=> rdata == fpa_pkg::RD_IDLE
  ) else $error("Read data stood beyond one cycle");

  AST_PULLUP: assert property (
    !is_addr && !hw_standby |=> pullup_on == (~$past(ddr_r) & $past(pcr_r))
  ) else $error("Pull-up not equal to input and control bit");

  AST_PULLUP_OFF: assert property (
    is_addr || hw_standby |=> pullup_on == '0
  ) else $error("Pull-up on in address mode or hardware standby");

  AST_DATA_WRITE: assert property (
    bus.wr && sel_data && !init_now |=> dr_r == $past(bus.wdata[PORT_W-1:0])
  ) else $error("Data register write lost");

  ////////////////////////////////////////////////////////////////////////////
  // Reset and retention; the reset checks opt out of the default disable

  AST_RESET_OFF: assert property (
    disable iff (1'b0)
    rst |=> pin_oe == '0 && pullup_on == '0
  ) else $error("Pins or pull-ups active during reset");

  AST_RESET_DIR: assert property (
    disable iff (1'b0)
    rst |=> (is_addr ? ddr_r == '1 : ddr_r == '0)
  ) else $error("Direction not initialised by reset");

  AST_RESET_DATA: assert property (
    disable iff (1'b0)
    rst |=> dr_r == fpa_pkg::RST_DATA[PORT_W-1:0]
  ) else $error("Data register not initialised by reset");

  AST_RESET_PULL: assert property (
    disable iff (1'b0)
    rst |=> pcr_r == fpa_pkg::RST_PULL[PORT_W-1:0]
  ) else $error("Pull-up control not initialised by reset");

  AST_DIR_HOLD: assert property (
    !(bus.wr && sel_dir) && !init_now |=> $stable(ddr_r)
  ) else $error("Direction changed without a write");

  AST_DATA_HOLD: assert property (
    !(bus.wr && sel_data) && !init_now |=> $stable(dr_r)
  ) else $error("Data register changed without a write");

  AST_PULL_HOLD: assert property (
    !(bus.wr && sel_pull) && !init_now |=> $stable(pcr_r)
  ) else $error("Pull-up control changed without a write");

  AST_MODE_HELD: assert property (
    !init_now |=> $stable(cls_r)
  ) else $error("Pin function class changed outside initialisation");

  AST_PULL_WRITE: assert property (
    bus.wr && sel_pull && !init_now |=> pcr_r == $past(bus.wdata[PORT_W-1:0])
  ) else $error("Pull-up control write lost");

  AST_DIR_WRITE_ADDR: assert property (
    bus.wr && sel_dir && is_addr && !init_now |=> ddr_r == '1
  ) else $error("Direction write took effect in address mode");

  AST_DATA_RSVD: assert property (
    bus.rd && sel_data |=> rdata[7:4] == fpa_pkg::RSVD_ONES
  ) else $error("Data read upper nibble not all ones");

  AST_PULL_RSVD: assert property (
    bus.rd && sel_pull |=> rdata[7:4] == fpa_pkg::RSVD_ONES
  ) else $error("Pull-up control read upper nibble not all ones");

  AST_HW_PINS_OFF: assert property (
    hw_standby |=> pin_oe == '0 && pin_out == '0
  ) else $error("Pins not released in hardware standby");

  AST_MIXED_PULLUP: assert property (
    is_mixed && !hw_standby |=> (pullup_on & $past(ddr_r)) == '0
  ) else $error("Pull-up on at an address output pin");

  AST_SW_GPIO_DRIVE: assert property (
    sw_standby && !is_addr && !hw_standby |=> pin_oe == $past(ddr_r)
  ) else $error("Output pin released in software standby");

  COV_MIXED_ADDR_OUT: cover property (
    is_mixed && ddr_r != '0 ##1 pin_oe != '0
  );

  COV_SINGLE_READ: cover property (
    !is_addr && !is_mixed && bus.rd && sel_data && ddr_r != '0 && ddr_r != '1
  );

  COV_SW_STANDBY_OUT: cover property (
    sw_standby && pin_oe != '0 [*4]
  );

  COV_PULLUP_ON: cover property (
    pullup_on != '0
  );

  COV_HW_STANDBY_EXIT: cover property (
    $fell(hw_standby) ##1 pin_oe == '0
  );

endmodule

// file: shared/fpa_pkg.sv
// Constants, types and helper function shared by the 4-bit port / address mux
//
// Functional notes
// - Modes 1-4 drive pins as upper address
// - Modes 5-6 direction bit picks address or input
// - Modes 5-6 all pins inputs after reset
// - Mode 7 direction bit picks output or input
// - Modes 1-4 direction fixed ones, writes ignored
// - Modes 5-7 direction low nibble writable, reads ones
// - Direction init FF or F0 by mode
// - Software standby keeps direction, outputs keep driving
// - Direction/pull-up upper nibble reserved, read one
// - Output data bits drive general-purpose output pins
// - Data read mixes stored bits and pin levels
// - Output data init F0, kept in software standby
// - Pull-up on when input and control set
// - Pull-ups off modes 1-4, reset, hardware standby
// - Pull-up control init F0, kept in software standby
package fpa_pkg;

  localparam int PORT_W = 4;

  // Register offsets (low 16 bits of the CPU address)
  localparam logic [15:0] ADDR_DIR  = 16'hffc8;
  localparam logic [15:0] ADDR_DATA = 16'hffca;
  localparam logic [15:0] ADDR_PULL = 16'hffdb;

  // Field positions of the implemented pin bits
  localparam int PIN_LSB = 0;
  localparam int PIN_MSB = 3;

  // Reset values
  localparam logic [7:0] RST_DIR_ADDR = 8'hff;
  localparam logic [7:0] RST_DIR_IO   = 8'hf0;
  localparam logic [7:0] RST_DATA     = 8'hf0;
  localparam logic [7:0] RST_PULL     = 8'hf0;

  // Read values
  localparam logic [3:0] RSVD_ONES    = 4'hf;
  localparam logic [7:0] RD_DIR_VAL   = 8'hff;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  localparam logic [7:0] RD_IDLE      = 8'h00;

  // Pin function class, derived from the operating mode
  typedef enum logic [2:0] {
    CLS_ADDR   = 3'b001,
    CLS_MIXED  = 3'b010,
    CLS_SINGLE = 3'b100
  } fpa_cls_t;

  // One CPU register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } fpa_bus_req_t;

  // Drive controls for the pins
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pu;
  } fpa_pin_ctl_t;

  // Modes 1-4 address, 5-6 mixed, 7 (and unused 0) single chip
  function automatic fpa_cls_t fpa_classify(input logic [2:0] mode);
    fpa_cls_t c;
    c = CLS_SINGLE;
    if (mode >= 3'h1 && mode <= 3'h4) begin
      c = CLS_ADDR;
    end else if (mode == 3'h5 || mode == 3'h6) begin
      c = CLS_MIXED;
    end
    return c;
  endfunction

endpackage

// file: rtl/fpa_mode_dec.sv
// Mode latch: holds the pin function class taken at reset or hardware standby
`timescale 1ns/1ps
module fpa_mode_dec (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          hw_standby,
  input  wire logic [2:0]    mode,
  output fpa_pkg::fpa_cls_t  cls_r
);

  // Mode pins are only trusted while the chip is held in reset or hardware standby
  always_ff @(posedge clk_sys) begin
    if (rst || hw_standby) begin
      cls_r <= fpa_pkg::fpa_classify(mode);
    end
  end

endmodule

// file: rtl/fpa_pin_mux.sv
// Per-pin function select: address output, general-purpose output or input
`timescale 1ns/1ps
module fpa_pin_mux (
  input  wire logic          cls_addr,
  input  wire logic          cls_mixed,
  input  wire logic          blocked,
  input  wire logic          dir,
  input  wire logic          data,
  input  wire logic          pull,
  input  wire logic          addr_bit,
  output logic               pin_out,
  output logic               pin_oe,
  output logic               pin_pu
);

  always_comb begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    pin_pu  = 1'b0;
    if (blocked) begin
      // Hardware standby: pin released, pull-up off
      pin_oe = 1'b0;
    end else if (cls_addr) begin
      pin_out = addr_bit;
      pin_oe  = 1'b1;
    end else if (cls_mixed) begin
      pin_out = dir & addr_bit;
      pin_oe  = dir;
      pin_pu  = ~dir & pull;
    end else begin
      pin_out = dir & data;
      pin_oe  = dir;
      pin_pu  = ~dir & pull;
    end
  end

endmodule

// file: dv/fpa_pin_model.sv
// Far-side model of the port: external drivers and pull-up resistors
`timescale 1ns/1ps
module fpa_pin_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pullup_on,
  input  wire logic [3:0] ext_val,
  input  wire logic [3:0] ext_en,
  input  wire logic       clk_sys,
  output logic [3:0]      pin_in
);
  // Known start level, so a floating pin toggles instead of staying unknown
  logic [3:0] last_r = 4'h0;

  // A floating pin flips every cycle so that a stale level never reads back right
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : ~last_r[i];
    end
  end

  always @(posedge clk_sys) begin
    last_r <= pin_in;
  end
endmodule

// file: dv/tb_fpa_port.sv
// Self-checking bench of the 4-bit port shared with the upper address outputs
`timescale 1ns/1ps
module tb_fpa_port;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] pul;
    logic [3:0] ext;
    logic [3:0] en;
  } fpa_row_t;

  logic                  clk_sys;
  logic                  rst;
  logic [2:0]            mode;
  logic                  hw_standby;
  logic                  sw_standby;
  fpa_pkg::fpa_bus_req_t bus;
  logic [7:0]            rdata;
  logic [3:0]            upper_addr;
  logic [3:0]            pin_in;
  logic [3:0]            pin_out;
  logic [3:0]            pin_oe;
  logic [3:0]            pullup_on;
  logic [3:0]            ext_val;
  logic [3:0]            ext_en;
  logic [3:0]            d;
  fpa_pkg::fpa_pin_ctl_t e;
  fpa_row_t              rows [6];
  int                    err_total;
  int                    checked;

  fpa_port DUT (.clk_sys(clk_sys), .rst(rst), .mode(mode), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .bus(bus), .rdata(rdata), .upper_addr(upper_addr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on));

  fpa_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_en(ext_en), .clk_sys(clk_sys), .pin_in(pin_in));

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input fpa_pkg::fpa_pin_ctl_t got, input fpa_pkg::fpa_pin_ctl_t exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t pins got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Mode is only latched while reset or hardware standby is high, so every mode change goes through here
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk_sys);
    mode <= m;
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    cmp_rd(rdata, exp);
  endtask

  // Pin controls are registered: looked at one edge after their cause settles
  task automatic chk_pins(input fpa_pkg::fpa_pin_ctl_t exp);
    @(posedge clk_sys);
    #1;
    cmp_pin('{out: pin_out, oe: pin_oe, pu: pullup_on}, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    mode = 3'h1;
    hw_standby = 1'b0;
    sw_standby = 1'b0;
    bus = '0;
    upper_addr = 4'ha;
    ext_val = 4'h0;
    ext_en = 4'h0;
    err_total = 0;
    checked = 0;
    rows = '{'{3'h1, 8'h00, 8'h5a, 8'hff, 4'h0, 4'h0},
             '{3'h4, 8'h03, 8'h3c, 8'h0f, 4'h0, 4'h0},
             '{3'h5, 8'h0c, 8'h93, 8'h0f, 4'h5, 4'hf},
             '{3'h6, 8'hff, 8'h60, 8'h00, 4'h0, 4'h0},
             '{3'h7, 8'h0a, 8'h76, 8'h05, 4'h0, 4'h0},
             '{3'h0, 8'h05, 8'hcf, 8'h00, 4'ha, 4'hf}};
    foreach (rows[i]) begin
      do_reset(rows[i].mode);
      ext_val <= rows[i].ext;
      ext_en <= rows[i].en;
      upper_addr <= rows[i].dat[7:4];
      d = (rows[i].mode inside {[3'h1:3'h4]}) ? 4'hf : rows[i].dir[3:0];
      e.oe = d;
      e.pu = ~d & rows[i].pul[3:0];
      e.out = (rows[i].mode inside {[3'h1:3'h6]}) ? d & rows[i].dat[7:4] : d & rows[i].dat[3:0];
      wr(fpa_pkg::ADDR_DIR, rows[i].dir);
      wr(fpa_pkg::ADDR_DATA, rows[i].dat);
      wr(fpa_pkg::ADDR_PULL, rows[i].pul);
      chk_pins(e);
      rd(fpa_pkg::ADDR_DATA, {4'hf, (d & rows[i].dat[3:0]) | (~d & rows[i].pul[3:0] & ~rows[i].en) |
        (~d & rows[i].ext & rows[i].en)});
      rd(fpa_pkg::ADDR_DIR, 8'hff);
      rd(fpa_pkg::ADDR_PULL, {4'hf, rows[i].pul[3:0]});
    end
    // Mixed mode comes out of reset with every pin an input
    do_reset(3'h5);
    ext_en <= 4'hf;
    ext_val <= 4'h6;
    chk_pins('0);
    rd(fpa_pkg::ADDR_DATA, 8'hf6);
    rd(fpa_pkg::ADDR_PULL, 8'hf0);
    wr(16'hffcc, 8'h0f);
    chk_pins('0);
    rd(16'hffc9, 8'h00);
    rd(fpa_pkg::ADDR_DIR, 8'hff);
    #1;
    @(posedge clk_sys);
    #1;
    cmp_rd(rdata, 8'h00);
    // Software standby: outputs keep driving, registers keep their contents
    do_reset(3'h7);
    wr(fpa_pkg::ADDR_DIR, 8'h0f);
    wr(fpa_pkg::ADDR_DATA, 8'h09);
    wr(fpa_pkg::ADDR_PULL, 8'h0f);
    sw_standby <= 1'b1;
    repeat (5) chk_pins('{out: 4'h9, oe: 4'hf, pu: 4'h0});
    @(posedge clk_sys);
    sw_standby <= 1'b0;
    rd(fpa_pkg::ADDR_DATA, 8'hf9);
    rd(fpa_pkg::ADDR_PULL, 8'hff);
    // Hardware standby re-initialises everything and releases the pins
    @(posedge clk_sys);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_pins('0);
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    ext_val <= 4'h3;
    chk_pins('0);
    rd(fpa_pkg::ADDR_DATA, 8'hf3);
    rd(fpa_pkg::ADDR_PULL, 8'hf0);
    wr(fpa_pkg::ADDR_DIR, 8'h0f);
    rd(fpa_pkg::ADDR_DATA, 8'hf0);
    give_verdict();
  end
endmodule
